// ==== src/rss_pkg.sv ====
// Package for the reset and start-up sequencer: constants, types, map
package rss_pkg;

	// Oscillator selection codes
	typedef enum logic [2:0] {
		OSC_LP       = 3'h0,
		OSC_XT       = 3'h1,
		OSC_HS       = 3'h2,
		OSC_EC       = 3'h3,
		OSC_INT_IO   = 3'h4,
		OSC_INT_CLK  = 3'h5,
		OSC_RC_IO    = 3'h6,
		OSC_RC_CLK   = 3'h7
	} rss_osc_mode_t;

	// Configuration bits as one carrier
	typedef struct packed {
		logic          brownout_enable;
		logic          reset_pin_enable;
		logic          powerup_delay_disable;
		rss_osc_mode_t osc_mode;
	} rss_cfg_t;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_HOLD    = 3'b000,
		ST_POWERUP_DELAY_TIMER    = 3'b001,
		ST_OST     = 3'b010,
		ST_PIN     = 3'b011,
		ST_RUN     = 3'b100
	} rss_state_t;

	// Reset cause codes
	typedef enum logic [2:0] {
		CAUSE_NONE      = 3'h0,
		CAUSE_POR       = 3'h1,
		CAUSE_WDT_RUN   = 3'h2,
		CAUSE_WDT_SLEEP = 3'h3,
		CAUSE_PIN_RUN   = 3'h4,
		CAUSE_PIN_SLEEP = 3'h5,
		CAUSE_BROWNOUT  = 3'h6
	} rss_cause_t;

	// Register map, word offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_PCON   = 4'h1;
	localparam logic [3:0] REG_TRIM   = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;

	// PCON-like field positions
	localparam int PCON_BROWNOUT_BIT = 0;
	localparam int PCON_POWERON_BIT  = 1;

	// Reset values
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic [1:0] PCON_RST = 2'h0;

	// Timing
	localparam int CLK_HZ           = 25000000;
	localparam int POWERUP_DELAY_TIMER_MS          = 72;
	localparam int POWERUP_DELAY_TIMER_CYC         = (CLK_HZ / 1000) * POWERUP_DELAY_TIMER_MS;
	localparam int OST_OSC_CYC      = 1024;
	localparam int GLITCH_NS        = 2000;
	localparam int GLITCH_CYC       = (GLITCH_NS + 39) / 40;
	localparam int BOD_MIN_NS       = 100000;
	localparam int BOD_MIN_CYC      = (BOD_MIN_NS + 39) / 40;
	localparam int CLKDIV_HALF      = 2;

endpackage

// ==== src/rss_sequencer.sv ====
// Reset and start-up sequencer: cause decode, delay timers, flags, trim
//
// Contract
// [R1] Load calibration literal into oscillator trim register
// [R2] Drive clock divided by four when selected
// [R3] Distinguish six reset kinds
// [R4] Some registers kept across all non-power-on resets
// [R5] Others reset, but kept on watchdog wake
// [R6] Filter short pulses on external reset pin
// [R7] Watchdog reset never drives reset pin
// [R8] Internal option ties reset input inactive
// [R9] Cleared enable makes pin digital input
// [R10] Power-on holds reset until supply good
// [R11] Power-up delay 72 ms after power-on/brown-out
// [R12] Delay counts its own internal oscillator
// [R13] Disable bit set skips power-up delay
// [R14] Enable power-up delay whenever brown-out enabled; code does not force it, the disable bit still skips it
// [R15] Then wait 1024 crystal cycles
// [R16] Crystal count only crystal modes, power-on/wake
// [R17] Brown-out enable bit gates detection
// [R18] Long low supply causes brown-out reset
// [R19] Hold reset until supply above recovery level
// [R20] Brown-out skips delay when disable set
// [R21] Supply dip during delay restarts it
// [R22] Delay then crystal count; none for ext clock
// [R23] Delays run regardless of held reset pin
// [R24] Power-on flag zero on power-on only
// [R25] Brown-out flag cleared by hardware on brown-out
// [R26] Core release synchronised to system clock
`timescale 1ns/1ns
module rss_sequencer
	import rss_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYC
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// Configuration, analog comparators and slow clocks
	input  wire rss_cfg_t   cfg_i,
	input  wire logic       supply_ok_i,
	input  wire logic       above_brownout_i,
	input  wire logic       powerup_delay_timer_osc_tick_i,
	input  wire logic       osc_clk_pin_i,
	// Reset pin and watchdog
	input  wire logic       reset_pin_n_i,
	input  wire logic       watchdog_expired_i,
	input  wire logic       sleeping_i,
	// Calibration load
	input  wire logic       trim_load_i,
	input  wire logic [7:0] trim_literal_i,
	// Register port
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Outputs
	output logic            core_reset_n_o,
	output logic            keep_regs_o,
	output logic            pin_digital_o,
	output logic            pin_digital_val_o,
	output logic            reset_pin_oe_o,
	output logic            divided_clock_output_o,
	output logic            divided_clock_output_oe_o,
	output logic      [7:0] oscillator_trim_o,
	output rss_cause_t      cause_o
);

	localparam int POWERUP_DELAY_TIMER_W = $clog2(POWERUP_DELAY_TIMER_CYCLES + 1);
	localparam logic [POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST = POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1);

	// Two-flop synchronisers for every asynchronous input
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge clock_i) begin
		sync1_r <= {supply_ok_i, above_brownout_i, powerup_delay_timer_osc_tick_i,
			osc_clk_pin_i, reset_pin_n_i};
		sync2_r <= sync1_r;
	end
	logic supply_ok_s, above_bod_s, powerup_delay_timer_tick_s, osc_pin_s, pin_n_s;
	assign {supply_ok_s, above_bod_s, powerup_delay_timer_tick_s, osc_pin_s, pin_n_s} =
		sync2_r;

	// Edge detection on synchronised slow clocks
	logic powerup_delay_timer_tick_d_r;
	logic osc_pin_d_r;
	always_ff @(posedge clock_i) begin
		powerup_delay_timer_tick_d_r <= powerup_delay_timer_tick_s;
		osc_pin_d_r   <= osc_pin_s;
	end
	logic powerup_delay_timer_step;
	logic osc_step;
	assign powerup_delay_timer_step = powerup_delay_timer_tick_s & ~powerup_delay_timer_tick_d_r; // [R12]
	assign osc_step  = osc_pin_s & ~osc_pin_d_r;

	// Reset pin: filtered, or tied high when the pin is digital I/O
	logic       pin_filt_r;
	logic [7:0] glitch_cnt_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pin_filt_r   <= 1'b1;
			glitch_cnt_r <= 8'h00;
		end else if (!cfg_i.reset_pin_enable) begin
			pin_filt_r   <= 1'b1; // [R8] [R9]
			glitch_cnt_r <= 8'h00;
		end else if (pin_n_s == pin_filt_r) begin
			glitch_cnt_r <= 8'h00;
		end else if (glitch_cnt_r == 8'(GLITCH_CYC - 1)) begin
			pin_filt_r   <= pin_n_s; // [R6]
			glitch_cnt_r <= 8'h00;
		end else begin
			glitch_cnt_r <= glitch_cnt_r + 8'h01;
		end
	end
	logic pin_reset;
	assign pin_reset = ~pin_filt_r;
	assign pin_digital_o     = ~cfg_i.reset_pin_enable; // [R9]
	assign pin_digital_val_o = pin_n_s;
	// Pin is input only; a watchdog event is never driven out
	assign reset_pin_oe_o    = 1'b0; // [R7]

	// Brown-out qualifier: low must persist before acting
	logic        bod_low_r;
	logic [11:0] bod_cnt_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !cfg_i.brownout_enable || above_bod_s) begin
			bod_low_r <= 1'b0; // [R17]
			bod_cnt_r <= 12'h000;
		end else if (bod_cnt_r == 12'(BOD_MIN_CYC - 1)) begin
			bod_low_r <= 1'b1; // [R18]
		end else begin
			bod_cnt_r <= bod_cnt_r + 12'h001;
		end
	end
	// Recovery: held while below level once brown-out has fired
	logic bod_hold;
	assign bod_hold = cfg_i.brownout_enable & ~above_bod_s; // [R19] [R21]

	// Power-on: chip reset deasserts only via supply good; no reset on fall
	logic por_seen_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			por_seen_r <= 1'b0;
		else if (supply_ok_s)
			por_seen_r <= 1'b1; // [R10]
	end

	logic crystal_mode;
	assign crystal_mode = (cfg_i.osc_mode == OSC_LP) ||
		(cfg_i.osc_mode == OSC_XT) || (cfg_i.osc_mode == OSC_HS);

	// Sequencer
	rss_state_t       state_r;
	rss_cause_t       cause_r;
	logic             ost_wanted_r;
	logic [POWERUP_DELAY_TIMER_W-1:0] powerup_delay_timer_cnt_r;
	logic [10:0]       ost_cnt_r;
	logic              wake_r;

	logic wdt_event;
	assign wdt_event = watchdog_expired_i && state_r == ST_RUN;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !por_seen_r) begin
			state_r      <= ST_HOLD;
			cause_r      <= CAUSE_POR;
			ost_wanted_r <= 1'b1;
			powerup_delay_timer_cnt_r   <= '0;
			ost_cnt_r    <= 11'h000;
			wake_r       <= 1'b0;
		end else if (bod_low_r || (bod_hold && state_r != ST_RUN &&
			cause_r == CAUSE_BROWNOUT)) begin
			state_r      <= ST_HOLD; // [R21]
			cause_r      <= CAUSE_BROWNOUT; // [R3]
			ost_wanted_r <= 1'b0; // [R16]
			powerup_delay_timer_cnt_r   <= '0;
			wake_r       <= 1'b0;
		end else begin
			case (state_r)
				ST_HOLD: begin
					powerup_delay_timer_cnt_r <= '0;
					ost_cnt_r  <= 11'h000;
					if (!bod_hold) begin // [R19]
						if (!cfg_i.powerup_delay_disable &&
							(cause_r == CAUSE_POR ||
							cause_r == CAUSE_BROWNOUT))
							state_r <= ST_POWERUP_DELAY_TIMER; // [R11] [R13] [R20]
						else if (crystal_mode && ost_wanted_r)
							state_r <= ST_OST; // [R16]
						else
							state_r <= ST_PIN; // [R22]
					end
				end
				ST_POWERUP_DELAY_TIMER: begin
					if (powerup_delay_timer_step) begin
						if (powerup_delay_timer_cnt_r == POWERUP_DELAY_TIMER_LAST) begin
							state_r <= (crystal_mode && ost_wanted_r) ?
								ST_OST : ST_PIN; // [R15] [R22]
						end else begin
							powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r + 1'b1; // [R11]
						end
					end
				end
				ST_OST: begin
					if (osc_step) begin
						if (ost_cnt_r == 11'(OST_OSC_CYC - 1))
							state_r <= ST_PIN; // [R15]
						else
							ost_cnt_r <= ost_cnt_r + 11'h001;
					end
				end
				ST_PIN: begin
					// Delays already ran; pin release starts at once
					if (!pin_reset)
						state_r <= ST_RUN; // [R23]
				end
				ST_RUN: begin
					wake_r <= 1'b0;
					if (wdt_event && sleeping_i) begin
						// Wake from sleep keeps state; crystal restarts
						cause_r      <= CAUSE_WDT_SLEEP; // [R3]
						wake_r       <= 1'b1; // [R5]
						ost_wanted_r <= 1'b1; // [R16]
						state_r      <= crystal_mode ? ST_OST : ST_PIN;
						ost_cnt_r    <= 11'h000;
					end else if (wdt_event) begin
						cause_r      <= CAUSE_WDT_RUN; // [R3] [R7]
						ost_wanted_r <= 1'b0;
						state_r      <= ST_HOLD;
					end else if (pin_reset) begin
						cause_r      <= sleeping_i ? CAUSE_PIN_SLEEP :
							CAUSE_PIN_RUN; // [R3]
						ost_wanted_r <= 1'b0;
						state_r      <= ST_HOLD;
					end
				end
				default: state_r <= ST_HOLD;
			endcase
		end
	end

	// Release to core registered on the system clock
	logic release_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			release_r <= 1'b0;
		else
			release_r <= (state_r == ST_RUN); // [R26]
	end
	assign core_reset_n_o = release_r;
	// Held registers only lose content on power-on
	assign keep_regs_o = (cause_r != CAUSE_POR) || wake_r; // [R4] [R5]
	assign cause_o     = cause_r;

	// Power control flags and trim
	logic [1:0] pcon_r;
	logic [7:0] trim_r;
	logic       pcon_wr;
	logic       trim_wr;
	assign pcon_wr = reg_wr_i && reg_addr_i == REG_PCON;
	assign trim_wr = reg_wr_i && reg_addr_i == REG_TRIM;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !por_seen_r) begin
			pcon_r <= PCON_RST; // [R24]
		end else begin
			if (pcon_wr)
				pcon_r <= reg_wdata_i[1:0];
			// Hardware clear wins over a same-cycle software write
			if (bod_low_r)
				pcon_r[PCON_BROWNOUT_BIT] <= 1'b0; // [R25]
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			trim_r <= TRIM_RST;
		else if (trim_load_i)
			trim_r <= trim_literal_i; // [R1]
		else if (trim_wr)
			trim_r <= reg_wdata_i;
	end
	assign oscillator_trim_o = trim_r;

	// Divided clock out: system clock / 4 in the OSC_INT_CLK or OSC_RC_CLK modes only
	logic [1:0] div_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			div_r <= 2'h0;
		else
			div_r <= div_r + 2'h1;
	end
	logic divided_clock_output_en;
	assign divided_clock_output_en = (cfg_i.osc_mode == OSC_INT_CLK) ||
		(cfg_i.osc_mode == OSC_RC_CLK);
	logic divided_clock_output_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			divided_clock_output_r <= 1'b0;
		else
			divided_clock_output_r <= divided_clock_output_en & div_r[1]; // [R2]
	end
	assign divided_clock_output_o    = divided_clock_output_r;
	assign divided_clock_output_oe_o = divided_clock_output_en; // [R2]

	// Register read, data one cycle after strobe
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i) begin
			if (reg_addr_i == REG_PCON)
				reg_rdata_o <= {6'h00, pcon_r};
			else if (reg_addr_i == REG_TRIM)
				reg_rdata_o <= trim_r;
			else if (reg_addr_i == REG_STATUS)
				reg_rdata_o <= {2'h0, state_r, cause_r};
			else if (reg_addr_i == REG_CTRL)
				reg_rdata_o <= {2'h0, cfg_i};
			else
				reg_rdata_o <= 8'h00;
		end else
			reg_rdata_o <= 8'h00;
	end

endmodule

// ==== tb/rss_far_model.sv ====
// Far-side model: supply monitors, delay oscillator, crystal and reset pin
`timescale 1ns/1ns
module rss_far_model (
	// Controls from the bench
	input  wire logic pin_low_i,
	input  wire logic dip_i,
	// Lines into the sequencer
	output logic      supply_ok_o,
	output logic      above_bo_o,
	output logic      tick_o,
	output logic      osc_o,
	output logic      pin_n_o
);
	// Supply rises once and never falls again
	initial begin
		supply_ok_o = 1'b0;
		#101 supply_ok_o = 1'b1;
	end
	// Both run free; odd edge times keep them off the clock edges, and
	// the crystal stays below half the system clock so no edge is lost
	initial begin
		tick_o = 1'b0;
		#1;
		forever #500 tick_o = ~tick_o;
	end
	initial begin
		osc_o = 1'b0;
		#1;
		forever #60 osc_o = ~osc_o;
	end
	assign above_bo_o = supply_ok_o & ~dip_i;
	assign pin_n_o = ~pin_low_i;
endmodule

// ==== tb/rss_sequencer_chk.sv ====
// Port checker for the sequencer, bound to the design
`timescale 1ns/1ns
module rss_sequencer_chk
	import rss_pkg::*;
#(
	parameter int POWERUP_DELAY_TIMER_CYCLES = 8
) (
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire rss_cfg_t   cfg_i,
	input wire logic       above_brownout_i,
	input wire logic       reset_pin_n_i,
	input wire logic       watchdog_expired_i,
	input wire logic       sleeping_i,
	input wire logic       trim_load_i,
	input wire logic [7:0] trim_literal_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       core_reset_n_o,
	input wire logic       keep_regs_o,
	input wire logic       pin_digital_o,
	input wire logic       reset_pin_oe_o,
	input wire logic       divided_clock_output_o,
	input wire logic [7:0] oscillator_trim_o,
	input wire rss_cause_t cause_o
);
	logic [7:0]  pin_cnt_r;
	logic [11:0] bo_cnt_r;
	logic        clk_sel;

	assign clk_sel = cfg_i.osc_mode inside {OSC_INT_CLK, OSC_RC_CLK};

	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !cfg_i.reset_pin_enable || reset_pin_n_i) begin
			pin_cnt_r <= 8'h0;
		end else if (pin_cnt_r != 8'hff) begin
			pin_cnt_r <= pin_cnt_r + 8'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !cfg_i.brownout_enable || above_brownout_i) begin
			bo_cnt_r <= 12'h0;
		end else if (bo_cnt_r != 12'hfff) begin
			bo_cnt_r <= bo_cnt_r + 12'h1;
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	a_pin_never_driven: assert property (!reset_pin_oe_o)
		else $error("reset pin output enable raised");
	a_pin_digital_cfg: assert property (
		pin_digital_o == !cfg_i.reset_pin_enable)
		else $error("pin function does not follow enable bit");
	a_divided_clock_output_off: assert property (!clk_sel [*3] |-> !divided_clock_output_o)
		else $error("clock output active when not selected");
	a_divided_clock_output_period: assert property (
		$rose(divided_clock_output_o) && clk_sel |->
		divided_clock_output_o [*2] ##1 !divided_clock_output_o [*2] ##1 divided_clock_output_o)
		else $error("clock output not a divide by four");
	a_pin_holds_core: assert property (
		pin_cnt_r >= 8'h40 |-> !core_reset_n_o)
		else $error("core runs while reset pin held low");
	a_brownout_fires: assert property (
		bo_cnt_r == 12'h9d8 |-> !core_reset_n_o && cause_o == CAUSE_BROWNOUT)
		else $error("long supply dip did not reset");
	a_read_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h0)
		else $error("read data outside read cycle");
	a_trim_load: assert property (
		trim_load_i |=> oscillator_trim_o == $past(trim_literal_i))
		else $error("trim literal not loaded");
	a_watchdog_reset: assert property (
		watchdog_expired_i && core_reset_n_o && !sleeping_i |->
		##[1:3] (!core_reset_n_o && cause_o == CAUSE_WDT_RUN && keep_regs_o))
		else $error("watchdog reset not taken");

	c_release: cover property ($rose(core_reset_n_o));
	c_brownout: cover property (bo_cnt_r == 12'h9d8);
	c_divided_clock_output: cover property ($rose(divided_clock_output_o) && clk_sel);
endmodule

bind rss_sequencer rss_sequencer_chk #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES))
	u_rss_sequencer_chk (.*);

// ==== tb/tb_reset_and_startup_sequencer.sv ====
// Testbench for the reset and start-up sequencer
`timescale 1ns/1ns
module tb_reset_and_startup_sequencer
	import rss_pkg::*;
;
	logic clock_i, rst_n_i, supply_ok_i, above_brownout_i, powerup_delay_timer_osc_tick_i;
	logic osc_clk_pin_i, reset_pin_n_i, watchdog_expired_i, sleeping_i;
	logic trim_load_i, reg_wr_i, reg_rd_i, core_reset_n_o, keep_regs_o;
	logic pin_digital_o, pin_digital_val_o, reset_pin_oe_o, divided_clock_output_o;
	logic divided_clock_output_oe_o, pin_low, dip;
	logic [7:0] trim_literal_i, reg_wdata_i, reg_rdata_o, oscillator_trim_o;
	logic [3:0] reg_addr_i;
	rss_cfg_t   cfg_i;
	rss_cause_t cause_o;
	int         n_tests, fail_count, cyc, n;

	rss_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(8)) u_rss_sequencer (.*);
	rss_far_model u_rss_far_model (
		.pin_low_i  (pin_low),
		.dip_i      (dip),
		.supply_ok_o(supply_ok_i),
		.above_bo_o (above_brownout_i),
		.tick_o     (powerup_delay_timer_osc_tick_i),
		.osc_o      (osc_clk_pin_i),
		.pin_n_o    (reset_pin_n_i)
	);

	always #20 clock_i = ~clock_i;

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Cuts a hang short; the whole run needs under 10000 cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 chk("rdata", e, reg_rdata_o);
		@(posedge clock_i);
	endtask

	// Counts cycles until the core is let go, bounded by mx
	task automatic wrel(input int mx);
		n = 0;
		while (core_reset_n_o !== 1'b1 && n < mx) begin
			@(posedge clock_i);
			n++;
		end
		chk("core_run", 8'h1, {7'h0, core_reset_n_o});
	endtask

	task automatic boot(input rss_cfg_t c);
		rst_n_i <= 1'b0;
		cfg_i <= c;
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
	endtask

	initial begin
		clock_i = 1'b0;
		rst_n_i = 1'b0;
		cfg_i = '{1'b1, 1'b1, 1'b0, OSC_XT};
		{watchdog_expired_i, sleeping_i, trim_load_i, reg_wr_i} = 4'h0;
		{reg_rd_i, pin_low, dip} = 3'h0;
		{trim_literal_i, reg_wdata_i, reg_addr_i} = 20'h0;
		{n_tests, fail_count, cyc} = '0;
		@(posedge clock_i);
		// Brown-out on with the delay enabled, as recommended
		boot('{1'b1, 1'b1, 1'b0, OSC_XT});
		rd(REG_PCON, 8'h00);
		rd(REG_TRIM, 8'h80);
		trim_load_i <= 1'b1;
		trim_literal_i <= 8'h5a;
		@(posedge clock_i);
		trim_load_i <= 1'b0;
		rd(REG_TRIM, 8'h5a);
		wr(REG_TRIM, 8'h33);
		rd(REG_TRIM, 8'h33);
		chk("trim_out", 8'h33, oscillator_trim_o);
		chk("divided_clock_output_oe", 8'h0, {7'h0, divided_clock_output_oe_o});
		wr(REG_CTRL, 8'hff);
		rd(REG_CTRL, 8'h31);
		rd(4'hf, 8'h00);
		// 8 ticks of 25 cycles, then 1024 crystal edges 3 cycles apart
		wrel(4000);
		chk("powerup_delay_timer_ost", 8'h1, {7'h0, n >= 3200});
		$display("test power-on done");
		boot('{1'b0, 1'b1, 1'b1, OSC_EC});
		wrel(300);
		chk("no_delay", 8'h1, {7'h0, n < 150});
		$display("test no-delay done");
		pin_low <= 1'b1;
		repeat (20) @(posedge clock_i);
		pin_low <= 1'b0;
		repeat (10) @(posedge clock_i);
		chk("glitch", 8'h1, {7'h0, core_reset_n_o});
		pin_low <= 1'b1;
		repeat (100) @(posedge clock_i);
		chk("pin_rst", 8'h0, {7'h0, core_reset_n_o});
		chk("cause", {5'h0, CAUSE_PIN_RUN}, {5'h0, cause_o});
		chk("keep", 8'h1, {7'h0, keep_regs_o});
		pin_low <= 1'b0;
		wrel(100);
		$display("test pin done");
		watchdog_expired_i <= 1'b1;
		@(posedge clock_i);
		watchdog_expired_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		chk("cause", {5'h0, CAUSE_WDT_RUN}, {5'h0, cause_o});
		chk("pin_oe", 8'h0, {7'h0, reset_pin_oe_o});
		wrel(200);
		$display("test watchdog done");
		sleeping_i <= 1'b1;
		watchdog_expired_i <= 1'b1;
		@(posedge clock_i);
		watchdog_expired_i <= 1'b0;
		repeat (5) @(posedge clock_i);
		chk("cause", {5'h0, CAUSE_WDT_SLEEP}, {5'h0, cause_o});
		chk("keep", 8'h1, {7'h0, keep_regs_o});
		wrel(50);
		pin_low <= 1'b1;
		repeat (100) @(posedge clock_i);
		chk("pin_slp", 8'h0, {7'h0, core_reset_n_o});
		chk("cause", {5'h0, CAUSE_PIN_SLEEP}, {5'h0, cause_o});
		pin_low <= 1'b0;
		sleeping_i <= 1'b0;
		wrel(100);
		$display("test sleep done");
		boot('{1'b1, 1'b0, 1'b0, OSC_INT_CLK});
		wrel(400);
		// First tick may come at once: seven full tick periods at least
		chk("powerup_delay_timer", 8'h1, {7'h0, n >= 175});
		chk("digital", 8'h1, {7'h0, pin_digital_o});
		chk("divided_clock_output_oe", 8'h1, {7'h0, divided_clock_output_oe_o});
		pin_low <= 1'b1;
		wr(REG_PCON, 8'h03);
		rd(REG_PCON, 8'h03);
		chk("pin_off", 8'h1, {7'h0, core_reset_n_o});
		chk("pin_val", 8'h0, {7'h0, pin_digital_val_o});
		dip <= 1'b1;
		repeat (2600) @(posedge clock_i);
		chk("bo_rst", 8'h0, {7'h0, core_reset_n_o});
		dip <= 1'b0;
		rd(REG_PCON, 8'h02);
		wrel(400);
		chk("bo_powerup_delay_timer", 8'h1, {7'h0, n >= 175});
		pin_low <= 1'b0;
		$display("test brown-out done");
		summarize();
	end
endmodule
